// ==== rtl/hdlc_err_pkg.sv ====
// Constants for the HDLC channel error handling block
package hdlc_err_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CHCFG_OFS = 8'h04;
    localparam logic [7:0] ACTIVE_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;

    // Control, channel config, active and status register field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACM_BIT = 4;
    localparam int CTRL_FLM_BIT = 5;
    localparam int CTRL_OUT_OF_FRAME_ABORT_SETTING_BIT = 6;
    localparam int CHCFG_BEM_LSB = 0;
    localparam int CHCFG_INH_LSB = 4;
    localparam int ACTIVE_RX_LSB = 0;
    localparam int ACTIVE_TX_LSB = 4;
    localparam int STATUS_CNT_LSB = 8;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CHCFG_RESET = 32'h0000_0000;
    localparam logic [NUM_CH-1:0] ACTIVE_RESET = 4'h0;

    // Port framing modes
    localparam logic [2:0] MODE_UNFRAMED = 3'h0;
    localparam logic [2:0] MODE_T1 = 3'h1;
    localparam logic [2:0] MODE_E1 = 3'h2;
    localparam logic [2:0] MODE_E1X2 = 3'h3;
    localparam logic [2:0] MODE_E1X4 = 3'h4;

    // Bits per frame, minus one
    localparam logic [10:0] T1_LAST = 11'h0C0;
    localparam logic [10:0] E1_LAST = 11'h0FF;
    localparam logic [10:0] E1X2_LAST = 11'h1FF;
    localparam logic [10:0] E1X4_LAST = 11'h3FF;

    // Timing
    localparam int FRAME_TIME_NS = 125000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int FRAME_CYCLES = FRAME_TIME_NS / CLK_PERIOD_NS;
    localparam logic [3:0] ABORT_ONES_LAST = 4'hF;

    // Interrupt and status error codes
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_ONR = 4'h1;
    localparam logic [3:0] CODE_FIFO_FLOW_ERROR = 4'h2;
    localparam logic [3:0] CODE_FRAME_ALIGNMENT_CHANGE = 4'h3;
    localparam logic [3:0] CODE_OOF = 4'h4;
    localparam logic DIR_RX = 1'b0;
    localparam logic DIR_TX = 1'b1;

    // Frame check sequence
    localparam logic [15:0] FCS_INIT = 16'hFFFF;
    localparam logic [15:0] FCS_POLY = 16'h8408;
    localparam logic [15:0] FCS_GOOD = 16'hF0B8;

    typedef enum logic [0:0] {ALIGN_NORMAL, ALIGN_HOLD} align_e;
endpackage

// ==== rtl/hdlc_channel_error_handling.sv ====
// HDLC channel error detection and recovery for one channel group
// What this block does
// - Unexpected transmit frame sync rise against the flywheel flags alignment change.
// - Alignment check only in T1, E1, 2xE1, 4xE1 modes; hits all active channels.
// - Transmit alignment change held for one 125 us frame period.
// - Sending active transmit channels enter abort, sending repeated sixteen ones.
// - No descriptor update or end-of-buffer/message events unless already completed.
// - Descriptor polling stops; channels deactivate when the condition ends.
// - Host-owned next descriptor fetched mid-message raises ownership error.
// - A granted descriptor is kept and written until its buffer ends.
// - Ownership error posts receive interrupt unless buffer error mask set.
// - Ownership error discards FIFO and message, no status write, deactivates channel.
// - Bits arriving into full FIFO post receive overrun interrupt unless masked.
// - Overrun discards data, fetches next pointer, returns descriptor, hunts for flag.
// - Unexpected receive frame sync rise flags alignment change for 125 us.
// - Receiving channels discard message and hunt for flag before refilling FIFO.
// - Each hit receiving channel returns descriptor with alignment code unless inhibited.
// - One receive alignment interrupt after all channels serviced, unless masked.
// - Loss of frame posts receive out-of-frame interrupt unless masked.
// - With abort setting clear, out-of-frame leaves reception untouched.
// - With abort setting, discard, fetch pointer, return descriptor, recover hunting.
// - Received message check sequence compared; mismatch flags an FCS error.
`timescale 1ns/1ns
module hdlc_channel_error_handling
    import hdlc_err_pkg::*;
#(
    parameter int FRAME_ALIGNMENT_CHANGE_HOLD_CYCLES = FRAME_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link pins
    input wire logic serialClk,
    input wire logic txFrameSync,
    input wire logic rxFrameSync,
    input wire logic lossOfFrame,
    // Transmit channels
    input wire logic [NUM_CH-1:0] txSending,
    input wire logic [NUM_CH-1:0] txEobReq,
    input wire logic [NUM_CH-1:0] txEomReq,
    output logic [NUM_CH-1:0] txEobEvt,
    output logic [NUM_CH-1:0] txEomEvt,
    output logic [NUM_CH-1:0] txAbort,
    output logic txAbortWordStart,
    output logic [NUM_CH-1:0] txPollEn,
    // Receive channels
    input wire logic [NUM_CH-1:0] rxInMsg,
    input wire logic [NUM_CH-1:0] rxDescHostOwned,
    input wire logic [NUM_CH-1:0] rxBitStore,
    input wire logic [NUM_CH-1:0] rxFifoFull,
    input wire logic [NUM_CH-1:0] rxFlagSeen,
    output logic [NUM_CH-1:0] rxDiscard,
    output logic [NUM_CH-1:0] rxNextPtrFetch,
    // Frame check sequence stream
    input wire logic fcsMsgStart,
    input wire logic fcsBitValid,
    input wire logic fcsBit,
    input wire logic fcsMsgEnd,
    output logic fcsError,
    // Receive status descriptor writes
    output logic statValid,
    input wire logic statReady,
    output logic [CH_W-1:0] statChan,
    output logic [3:0] statCode,
    // Interrupt descriptor posts
    output logic intValid,
    input wire logic intReady,
    output logic [CH_W-1:0] intChan,
    output logic [3:0] intCode,
    output logic intDir
);

    function automatic logic [10:0] frameLast(input logic [2:0] mode);
        unique case (mode)
            MODE_T1: return T1_LAST;
            MODE_E1: return E1_LAST;
            MODE_E1X2: return E1X2_LAST;
            default: return E1X4_LAST;
        endcase
    endfunction

    function automatic logic [CH_W-1:0] firstOne(input logic [NUM_CH-1:0] v);
        logic [CH_W-1:0] idx;
        idx = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = CH_W'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [NUM_CH-1:0] oneHot(input logic [CH_W-1:0] idx);
        logic [NUM_CH-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    function automatic logic [15:0] fcsStep(input logic [15:0] crc, input logic b);
        return (crc[0] ^ b) ? ((crc >> 1) ^ FCS_POLY) : (crc >> 1);
    endfunction

    // Registers
    logic [31:0] ctrl_q;
    logic [31:0] chcfg_q;
    logic [NUM_CH-1:0] rxActive_q;
    logic [NUM_CH-1:0] txActive_q;
    logic [31:0] prdata_q;

    // Pin synchronisers; index 0 receive path, 1 transmit path
    logic sclkMeta_q, sclkSync_q, sclkPrev_q;
    logic [1:0] syncMeta_q, syncSync_q, syncPrev_q;
    logic oofMeta_q, oofSync_q, oofPrev_q;

    // Flywheel and hold state
    logic [10:0] flyCnt_q [2];
    logic [1:0] locked_q;
    align_e alignState_q [2];
    logic [15:0] holdCnt_q [2];

    // Channel state
    logic [NUM_CH-1:0] rxDiscard_q;
    logic [NUM_CH-1:0] rxNextPtrFetch_q;
    logic [NUM_CH-1:0] statPend_q;
    logic [3:0] statCodeMem_q [NUM_CH];
    logic [NUM_CH-1:0] txAbort_q;
    logic [3:0] onesCnt_q;

    // Interrupt pending flags
    logic [NUM_CH-1:0] intOnr_q;
    logic [NUM_CH-1:0] intBuff_q;
    logic intTxCofa_q, intRxCofa_q, intOof_q;

    // Output stages
    logic statValid_q, intValid_q, intDir_q;
    logic [CH_W-1:0] statChan_q, intChan_q;
    logic [3:0] statCode_q, intCode_q;

    // Frame check sequence state
    logic [15:0] crc_q;
    logic fcsError_q;
    logic [7:0] fcsErrCnt_q;

    // Register decode
    wire setupPhase = psel & ~penable;
    wire accessPhase = psel & penable;
    wire mapped = (paddr == CTRL_OFS) | (paddr == CHCFG_OFS) | (paddr == ACTIVE_OFS) | (paddr == STATUS_OFS);
    wire wrEn = accessPhase & pwrite;
    wire wrCtrl = wrEn & (paddr == CTRL_OFS);
    wire wrChcfg = wrEn & (paddr == CHCFG_OFS);
    wire wrActive = wrEn & (paddr == ACTIVE_OFS);
    wire [2:0] portMode = ctrl_q[CTRL_MODE_LSB +: 3];
    wire alignMask = ctrl_q[CTRL_ACM_BIT];
    wire frameLossMask = ctrl_q[CTRL_FLM_BIT];
    wire oofAbortSet = ctrl_q[CTRL_OUT_OF_FRAME_ABORT_SETTING_BIT];
    wire [NUM_CH-1:0] bufErrMask = chcfg_q[CHCFG_BEM_LSB +: NUM_CH];
    wire [NUM_CH-1:0] rxInhibit = chcfg_q[CHCFG_INH_LSB +: NUM_CH];
    wire [NUM_CH-1:0] wrRxActive = pwdata[ACTIVE_RX_LSB +: NUM_CH];
    wire [NUM_CH-1:0] wrTxActive = pwdata[ACTIVE_TX_LSB +: NUM_CH];

    // Link edges and flywheel checks
    wire framed = (portMode == MODE_T1) | (portMode == MODE_E1) | (portMode == MODE_E1X2) | (portMode == MODE_E1X4);
    wire [10:0] lastBit = frameLast(portMode);
    wire serialRise = sclkSync_q & ~sclkPrev_q;
    wire [1:0] syncRise = {2{serialRise}} & syncSync_q & ~syncPrev_q;
    wire [1:0] cofaDetect;
    wire [1:0] holding;
    wire [1:0] holdEnd;
    assign cofaDetect[0] = syncRise[0] & locked_q[0] & framed & (flyCnt_q[0] != lastBit);
    assign cofaDetect[1] = syncRise[1] & locked_q[1] & framed & (flyCnt_q[1] != lastBit);
    assign holding[0] = (alignState_q[0] == ALIGN_HOLD);
    assign holding[1] = (alignState_q[1] == ALIGN_HOLD);
    assign holdEnd[0] = holding[0] & (holdCnt_q[0] == 16'h0000) & ~cofaDetect[0];
    assign holdEnd[1] = holding[1] & (holdCnt_q[1] == 16'h0000) & ~cofaDetect[1];
    wire oofEvent = oofSync_q & ~oofPrev_q;

    // Receive channel events
    wire [NUM_CH-1:0] onrEv = rxActive_q & rxInMsg & rxDescHostOwned & ~rxDiscard_q;
    wire [NUM_CH-1:0] buffEv = rxActive_q & rxBitStore & rxFifoFull & ~rxDiscard_q & ~onrEv;
    wire [NUM_CH-1:0] cofaHit = rxActive_q & rxInMsg & ~rxDiscard_q & {NUM_CH{cofaDetect[0]}} & ~onrEv;
    wire [NUM_CH-1:0] oofHit = rxActive_q & rxInMsg & ~rxDiscard_q & {NUM_CH{oofEvent & oofAbortSet}} & ~onrEv;
    wire [NUM_CH-1:0] abortEv = buffEv | cofaHit | oofHit;
    wire [NUM_CH-1:0] statSet = abortEv & ~rxInhibit;

    // Interrupt selection
    wire statIdle = (statPend_q == '0) & ~statValid_q;
    wire rxCofaReady = intRxCofa_q & statIdle & ~holding[0];
    wire pickOnr = |intOnr_q;
    wire pickBuff = ~pickOnr & (|intBuff_q);
    wire pickTx = ~pickOnr & ~pickBuff & intTxCofa_q;
    wire pickRx = ~pickOnr & ~pickBuff & ~intTxCofa_q & rxCofaReady;
    wire pickOof = ~pickOnr & ~pickBuff & ~intTxCofa_q & ~rxCofaReady & intOof_q;
    wire intAny = pickOnr | pickBuff | pickTx | pickRx | pickOof;
    wire loadInt = ~intValid_q & intAny;
    wire [CH_W-1:0] onrIdx = firstOne(intOnr_q);
    wire [CH_W-1:0] buffIdx = firstOne(intBuff_q);
    wire [CH_W-1:0] pickChan = pickOnr ? onrIdx : (pickBuff ? buffIdx : '0);
    wire [3:0] pickCode = pickOnr ? CODE_ONR : (pickBuff ? CODE_FIFO_FLOW_ERROR : ((pickTx | pickRx) ? CODE_FRAME_ALIGNMENT_CHANGE : CODE_OOF));
    wire pickDir = pickTx ? DIR_TX : DIR_RX;
    wire [NUM_CH-1:0] onrClr = (loadInt & pickOnr) ? oneHot(onrIdx) : '0;
    wire [NUM_CH-1:0] buffClr = (loadInt & pickBuff) ? oneHot(buffIdx) : '0;

    // Status descriptor selection
    wire loadStat = ~statValid_q & (|statPend_q);
    wire [CH_W-1:0] statIdx = firstOne(statPend_q);
    wire [NUM_CH-1:0] statClr = loadStat ? oneHot(statIdx) : '0;

    // Channel outputs
    assign txAbort = txAbort_q;
    assign txPollEn = txActive_q & ~{NUM_CH{holding[1]}} & ~txAbort_q;
    assign txEobEvt = txEobReq & ~txAbort_q & ~({NUM_CH{holding[1]}} & txSending);
    assign txEomEvt = txEomReq & ~txAbort_q & ~({NUM_CH{holding[1]}} & txSending);
    assign txAbortWordStart = (|txAbort_q) & serialRise & (onesCnt_q == 4'h0);
    assign rxDiscard = rxDiscard_q | (rxActive_q & {NUM_CH{holding[0]}});
    assign rxNextPtrFetch = rxNextPtrFetch_q;
    assign fcsError = fcsError_q;
    assign statValid = statValid_q;
    assign statChan = statChan_q;
    assign statCode = statCode_q;
    assign intValid = intValid_q;
    assign intChan = intChan_q;
    assign intCode = intCode_q;
    assign intDir = intDir_q;
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~mapped;

    // Read data captured in the setup cycle
    wire [31:0] statusWord = {16'h0000, fcsErrCnt_q, 3'b000, locked_q[1], locked_q[0], oofSync_q, holding[0], holding[1]};
    wire [31:0] activeWord = {24'h000000, txActive_q, rxActive_q};
    wire [31:0] readMux = (paddr == CTRL_OFS) ? ctrl_q :
                          (paddr == CHCFG_OFS) ? chcfg_q :
                          (paddr == ACTIVE_OFS) ? activeWord :
                          (paddr == STATUS_OFS) ? statusWord : 32'h0000_0000;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
            chcfg_q <= CHCFG_RESET;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= pwdata;
            end
            if (wrChcfg) begin
                chcfg_q <= pwdata;
            end
            if (setupPhase) begin
                prdata_q <= readMux;
            end
        end
    end

    // Two-flop synchronisers, then edge history
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclkMeta_q <= 1'b0;
            sclkSync_q <= 1'b0;
            sclkPrev_q <= 1'b0;
            syncMeta_q <= 2'b00;
            syncSync_q <= 2'b00;
            syncPrev_q <= 2'b00;
            oofMeta_q <= 1'b0;
            oofSync_q <= 1'b0;
            oofPrev_q <= 1'b0;
        end else begin
            sclkMeta_q <= serialClk;
            sclkSync_q <= sclkMeta_q;
            sclkPrev_q <= sclkSync_q;
            syncMeta_q <= {txFrameSync, rxFrameSync};
            syncSync_q <= syncMeta_q;
            if (serialRise) begin
                syncPrev_q <= syncSync_q;
            end
            oofMeta_q <= lossOfFrame;
            oofSync_q <= oofMeta_q;
            oofPrev_q <= oofSync_q;
        end
    end

    // Flywheels and one-frame hold of the alignment-change condition
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            locked_q <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                flyCnt_q[i] <= 11'h000;
                alignState_q[i] <= ALIGN_NORMAL;
                holdCnt_q[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!framed) begin
                    locked_q[i] <= 1'b0;
                end else if (syncRise[i]) begin
                    locked_q[i] <= 1'b1;
                end
                if (syncRise[i] || (serialRise && flyCnt_q[i] == lastBit)) begin
                    flyCnt_q[i] <= 11'h000;
                end else if (serialRise) begin
                    flyCnt_q[i] <= flyCnt_q[i] + 11'h001;
                end
                unique case (alignState_q[i])
                    ALIGN_NORMAL: begin
                        if (cofaDetect[i]) begin
                            alignState_q[i] <= ALIGN_HOLD;
                            holdCnt_q[i] <= 16'(FRAME_ALIGNMENT_CHANGE_HOLD_CYCLES - 1);
                        end
                    end
                    ALIGN_HOLD: begin
                        if (cofaDetect[i]) begin
                            holdCnt_q[i] <= 16'(FRAME_ALIGNMENT_CHANGE_HOLD_CYCLES - 1);
                        end else if (holdEnd[i]) begin
                            alignState_q[i] <= ALIGN_NORMAL;
                        end else begin
                            holdCnt_q[i] <= holdCnt_q[i] - 16'h0001;
                        end
                    end
                endcase
            end
        end
    end

    // Transmit channels: abort, ones pattern phase, deactivation
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txActive_q <= ACTIVE_RESET;
            txAbort_q <= '0;
            onesCnt_q <= 4'h0;
        end else begin
            if (holdEnd[1]) begin
                txActive_q <= '0;
            end else if (wrActive) begin
                txActive_q <= wrTxActive;
            end
            if (wrActive) begin
                txAbort_q <= txAbort_q & ~wrTxActive;
            end
            if (cofaDetect[1] || holding[1]) begin
                txAbort_q <= txAbort_q | (txActive_q & txSending);
            end
            if (serialRise) begin
                onesCnt_q <= (onesCnt_q == ABORT_ONES_LAST) ? 4'h0 : onesCnt_q + 4'h1;
            end
        end
    end

    // Receive channels: discard, next pointer, deactivation, status queue
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxActive_q <= ACTIVE_RESET;
            rxDiscard_q <= '0;
            rxNextPtrFetch_q <= '0;
            statPend_q <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                statCodeMem_q[c] <= CODE_NONE;
            end
        end else begin
            if (wrActive) begin
                rxActive_q <= wrRxActive & ~onrEv;
            end else begin
                rxActive_q <= rxActive_q & ~onrEv;
            end
            rxNextPtrFetch_q <= abortEv;
            statPend_q <= (statPend_q & ~statClr) | statSet;
            for (int c = 0; c < NUM_CH; c++) begin
                if (onrEv[c] || abortEv[c]) begin
                    rxDiscard_q[c] <= 1'b1;
                end else if (rxFlagSeen[c] && !holding[0]) begin
                    rxDiscard_q[c] <= 1'b0;
                end
                if (statSet[c]) begin
                    statCodeMem_q[c] <= buffEv[c] ? CODE_FIFO_FLOW_ERROR : (cofaHit[c] ? CODE_FRAME_ALIGNMENT_CHANGE : CODE_OOF);
                end
            end
        end
    end

    // Status descriptor output stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            statValid_q <= 1'b0;
            statChan_q <= '0;
            statCode_q <= CODE_NONE;
        end else if (loadStat) begin
            statValid_q <= 1'b1;
            statChan_q <= statIdx;
            statCode_q <= statCodeMem_q[statIdx];
        end else if (statValid_q && statReady) begin
            statValid_q <= 1'b0;
        end
    end

    // Interrupt pending flags; a new event wins over the clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            intOnr_q <= '0;
            intBuff_q <= '0;
            intTxCofa_q <= 1'b0;
            intRxCofa_q <= 1'b0;
            intOof_q <= 1'b0;
        end else begin
            intOnr_q <= (intOnr_q & ~onrClr) | (onrEv & ~bufErrMask);
            intBuff_q <= (intBuff_q & ~buffClr) | (buffEv & ~bufErrMask);
            intTxCofa_q <= (intTxCofa_q & ~(loadInt & pickTx)) | (cofaDetect[1] & ~alignMask);
            intRxCofa_q <= (intRxCofa_q & ~(loadInt & pickRx)) | (cofaDetect[0] & ~alignMask);
            intOof_q <= (intOof_q & ~(loadInt & pickOof)) | (oofEvent & ~frameLossMask);
        end
    end

    // Interrupt descriptor output stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            intValid_q <= 1'b0;
            intChan_q <= '0;
            intCode_q <= CODE_NONE;
            intDir_q <= DIR_RX;
        end else if (loadInt) begin
            intValid_q <= 1'b1;
            intChan_q <= pickChan;
            intCode_q <= pickCode;
            intDir_q <= pickDir;
        end else if (intValid_q && intReady) begin
            intValid_q <= 1'b0;
        end
    end

    // Frame check sequence over the received message
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            crc_q <= FCS_INIT;
            fcsError_q <= 1'b0;
            fcsErrCnt_q <= 8'h00;
        end else begin
            fcsError_q <= 1'b0;
            if (fcsMsgStart) begin
                crc_q <= FCS_INIT;
            end else if (fcsBitValid) begin
                crc_q <= fcsStep(crc_q, fcsBit);
            end
            if (fcsMsgEnd && crc_q != FCS_GOOD) begin
                fcsError_q <= 1'b1;
                fcsErrCnt_q <= fcsErrCnt_q + 8'h01;
            end
        end
    end

endmodule

// ==== sim/hdlc_channel_error_handling_monitor.sv ====
// Port assertions for the error handling block
`timescale 1ns/1ns
module hdlc_channel_error_handling_monitor
    import hdlc_err_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Watched ports
    input wire logic [NUM_CH-1:0] txAbort, txPollEn, txEobEvt, txEomEvt, rxDiscard, rxNextPtrFetch,
    input wire logic statValid, statReady, intValid, intReady, intDir, fcsMsgEnd, fcsError,
    input wire logic [3:0] statCode, intCode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    end_blocked_a: assert property ((txAbort & (txEobEvt | txEomEvt)) == 4'h0) else $error("end event in abort");
    poll_stopped_a: assert property ($rose(|txAbort) |-> (txPollEn == 4'h0) [*8]) else $error("poll in hold");
    fetch_discards_a: assert property ((rxNextPtrFetch & ~rxDiscard) == 4'h0) else $error("fetch kept data");
    owner_no_status_a: assert property (statValid |-> statCode != CODE_ONR) else $error("ownership status");
    rx_int_dir_a: assert property (intValid && intCode != CODE_FRAME_ALIGNMENT_CHANGE |-> intDir == DIR_RX) else $error("int dir");
    int_held_a: assert property (intValid && !intReady |=> intValid && $stable(intCode)) else $error("int lost");
    stat_held_a: assert property (statValid && !statReady |=> statValid && $stable(statCode)) else $error("stat lost");
    fcs_timed_a: assert property (fcsError |-> $past(fcsMsgEnd)) else $error("stray check error");
    cover property (intValid && intCode == CODE_FIFO_FLOW_ERROR);
    cover property (intValid && intDir == DIR_TX);
    cover property (fcsError);
endmodule
bind hdlc_channel_error_handling hdlc_channel_error_handling_monitor i_hdlc_channel_error_handling_monitor (.*);

// ==== sim/link_partner.sv ====
// Framer model making the link clock and E1 frame syncs
`timescale 1ns/1ns
module link_partner (
    // Control
    input wire logic slip,
    // Link pins
    output logic serialClk,
    output logic txFrameSync,
    output logic rxFrameSync
);
    logic [7:0] bitCnt = 8'h00;
    initial begin
        serialClk = 1'b0;
        forever #80 serialClk = ~serialClk;
    end
    always @(negedge serialClk) bitCnt <= (slip && bitCnt == 8'h40) ? 8'hFF : bitCnt + 8'h01;
    assign txFrameSync = (bitCnt == 8'h00);
    assign rxFrameSync = txFrameSync;
endmodule

// ==== sim/hdlc_channel_error_handling_tb.sv ====
// Self-checking bench for the error handling block
`timescale 1ns/1ns
module hdlc_channel_error_handling_tb;
    import hdlc_err_pkg::*;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, serialClk, txFrameSync, rxFrameSync, err, v;
    logic lossOfFrame, slip, txAbortWordStart, fcsMsgStart, fcsBitValid, fcsBit, fcsMsgEnd, fcsError;
    logic statValid, statReady, intValid, intReady, intDir;
    logic [1:0] statChan, intChan;
    logic [3:0] txSending, txEobReq, txEomReq, txEobEvt, txEomEvt, txAbort, txPollEn, statCode, intCode;
    logic [3:0] rxInMsg, rxDescHostOwned, rxBitStore, rxFifoFull, rxFlagSeen, rxDiscard, rxNextPtrFetch;
    logic [5:0] st;
    logic [6:0] it;
    logic [7:0] paddr, cfg;
    logic [15:0] crc, d;
    logic [31:0] pwdata, prdata, rdv;
    int fails, comparisons, seed, ch, nS, nI, nF;
    hdlc_channel_error_handling #(.FRAME_ALIGNMENT_CHANGE_HOLD_CYCLES(20)) i_hdlc_channel_error_handling (.*);
    link_partner i_link_partner (.*);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        statReady <= 1'($random(seed));
        intReady <= 1'($random(seed));
        nF += int'(fcsError);
        nS += int'(statValid && statReady);
        if (statValid && statReady) st = {statChan, statCode};
        nI += int'(intValid && intReady);
        if (intValid && intReady) it = {intDir, intChan, intCode};
    end
    function automatic logic [15:0] fcs_step(input logic [15:0] c, input logic b);
        return (c >> 1) ^ ((c[0] ^ b) ? FCS_POLY : 16'h0000);
    endfunction
    task wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        @(posedge core_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, dat};
        @(posedge core_clk) penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task flag;
        rxFlagSeen <= 4'hF;
        @(posedge core_clk) rxFlagSeen <= 4'h0;
    endtask
    task report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        wt(60000);
        fails++;
        report_and_stop;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, lossOfFrame, slip, txSending, txEobReq, txEomReq} = '0;
        {rxInMsg, rxDescHostOwned, rxBitStore, rxFifoFull, rxFlagSeen, statReady, intReady} = '0;
        {fcsMsgStart, fcsBitValid, fcsBit, fcsMsgEnd} = '0;
        seed = 52;
        rst = 1'b1;
        wt(4);
        rst <= 1'b0;
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl reset", CTRL_RESET, rdv);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        apb(1'b1, ACTIVE_OFS, 32'hFF);
        rxInMsg <= 4'hF;
        for (int i = 0; i < 8; i++) begin
            ch = $random(seed) & 3;
            cfg = 8'($random(seed));
            apb(1'b1, CHCFG_OFS, 32'(cfg));
            {nS, nI} = '0;
            if (i[0]) rxDescHostOwned[ch] <= 1'b1;
            else {rxBitStore[ch], rxFifoFull[ch]} <= 2'b11;
            @(posedge core_clk) {rxDescHostOwned, rxBitStore, rxFifoFull} <= '0;
            wt(40);
            chk("int count", 32'(!cfg[ch]), nI);
            chk("stat count", 32'(!i[0] && !cfg[ch+4]), nS);
            if (nI == 1) chk("int desc", {DIR_RX, ch[1:0], i[0] ? CODE_ONR : CODE_FIFO_FLOW_ERROR}, it);
            if (nS == 1) chk("stat desc", {ch[1:0], CODE_FIFO_FLOW_ERROR}, st);
            apb(1'b0, ACTIVE_OFS, 32'h0);
            chk("active", i[0] ? 32'hFF & ~(32'h1 << ch) : 32'hFF, rdv);
            apb(1'b1, ACTIVE_OFS, 32'hFF);
            flag();
        end
        $display("test receive errors done");
        for (int k = 0; k < 2; k++) begin
            nF = 0;
            crc = FCS_INIT;
            fcsMsgStart <= 1'b1;
            for (int b = 0; b < 32; b++) begin
                v = (b < 16) ? 1'($random(seed)) : ~d[b-16] ^ (k == 1 && b == 21);
                crc = fcs_step(crc, v);
                if (b == 15) d = crc;
                @(posedge core_clk) {fcsMsgStart, fcsBitValid, fcsBit} <= {2'b01, v};
            end
            @(posedge core_clk) {fcsBitValid, fcsMsgEnd} <= 2'b01;
            @(posedge core_clk) fcsMsgEnd <= 1'b0;
            wt(3);
            chk("check errors", 32'(k), nF);
        end
        $display("test check sequence done");
        apb(1'b1, CHCFG_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'(MODE_E1));
        {txSending, txEobReq} <= 8'hFF;
        wt(11000);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("locked", 32'h3, 32'(rdv[4:3]));
        {nS, nI} = '0;
        slip <= 1'b1;
        for (int t = 0; t < 7000 && txAbort !== 4'hF; t++) @(posedge core_clk);
        slip <= 1'b0;
        chk("abort", 32'hF, 32'(txAbort));
        chk("end event", 32'h0, 32'(txEobEvt));
        wt(80);
        chk("stat count", 32'h4, nS);
        chk("int count", 32'h2, nI);
        chk("int desc", {DIR_RX, CODE_FRAME_ALIGNMENT_CHANGE}, {it[6], it[3:0]});
        apb(1'b0, ACTIVE_OFS, 32'h0);
        chk("active", 32'h0F, rdv);
        $display("test alignment change done");
        flag();
        {nS, nI} = '0;
        apb(1'b1, CTRL_OFS, 32'h40 | 32'(MODE_E1));
        lossOfFrame <= 1'b1;
        wt(60);
        chk("oof int", {DIR_RX, CODE_OOF}, {it[6], it[3:0]});
        chk("oof stat", 32'h4, nS);
        $display("test out of frame done");
        report_and_stop;
    end
endmodule
